// ==== hw/asbla_host.sv ====
// Host controller driving a 16-bit asynchronous static memory through its pins
`timescale 1ns/100ps
module asbla_host #(
	parameter int ADDR_WIDTH = asbla_pkg::ADDR_WIDTH
) (
	input  wire logic                            clock,
	input  wire logic                            rst,
	input  wire logic                            reqValid,
	input  wire logic                            reqWrite,
	input  wire logic [ADDR_WIDTH-1:0]           reqAddr,
	input  wire logic [asbla_pkg::DATA_WIDTH-1:0] reqData,
	input  wire logic [asbla_pkg::LANE_COUNT-1:0] reqByteEn,
	output logic                                 reqReady,
	output logic                                 rspValid,
	output logic [asbla_pkg::DATA_WIDTH-1:0]     rspData,
	output logic [ADDR_WIDTH-1:0]                sramAddr,
	output logic                                 chipSelectN,
	output logic                                 writeStrobeN,
	output logic                                 outputEnableN,
	output logic                                 upper_byte_enable_n,
	output logic                                 lower_byte_enable_n,
	input  wire logic [asbla_pkg::DATA_WIDTH-1:0] sramDataIn,
	output logic [asbla_pkg::DATA_WIDTH-1:0]     sramDataOut,
	output logic [asbla_pkg::LANE_COUNT-1:0]     sramDataOe
);

	asbla_pkg::asbla_state_e state_reg;

	logic [asbla_pkg::COUNT_WIDTH-1:0] count_reg;
	logic [ADDR_WIDTH-1:0]             addr_reg;
	logic                              chipSelectN_reg;
	logic                              writeStrobeN_reg;
	logic                              outputEnableN_reg;
	logic [asbla_pkg::LANE_COUNT-1:0]  byteEnN_reg;
	logic [asbla_pkg::DATA_WIDTH-1:0]  dataOut_reg;
	logic [asbla_pkg::LANE_COUNT-1:0]  dataOe_reg;
	logic                              reqReady_reg;
	logic                              rspValid_reg;
	logic [asbla_pkg::DATA_WIDTH-1:0]  rspData_reg;
	logic                              take;
	logic                              countDone;

	asbla_sync_if #(.WIDTH(asbla_pkg::DATA_WIDTH)) syncBus ();

	// Expand a lane mask into a bit mask
	function automatic logic [asbla_pkg::DATA_WIDTH-1:0] laneMask(
		input logic [asbla_pkg::LANE_COUNT-1:0] lanes
	);
		return {{asbla_pkg::LANE_WIDTH{lanes[1]}}, {asbla_pkg::LANE_WIDTH{lanes[0]}}};
	endfunction

	assign syncBus.rawData = sramDataIn;

	asbla_pin_sync #(
		.WIDTH (asbla_pkg::DATA_WIDTH)
	) pinSync (
		.clock (clock),
		.rst   (rst),
		.port  (syncBus.capture)
	);

	assign take      = (state_reg == asbla_pkg::ST_IDLE) && reqValid && reqReady_reg;
	assign countDone = (count_reg == asbla_pkg::COUNT_LAST);

	// Sequencer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= asbla_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				asbla_pkg::ST_IDLE: begin
					if (take) begin
						state_reg <= reqWrite ? asbla_pkg::ST_WR_SETUP : asbla_pkg::ST_RD_WAIT;
					end
				end
				asbla_pkg::ST_WR_SETUP: begin
					state_reg <= asbla_pkg::ST_WR_PULSE;
				end
				asbla_pkg::ST_WR_PULSE: begin
					if (countDone) begin
						state_reg <= asbla_pkg::ST_WR_HOLD;
					end
				end
				asbla_pkg::ST_WR_HOLD: begin
					state_reg <= asbla_pkg::ST_IDLE;
				end
				asbla_pkg::ST_RD_WAIT: begin
					if (countDone) begin
						state_reg <= asbla_pkg::ST_TURN;
					end
				end
				asbla_pkg::ST_TURN: begin
					if (countDone) begin
						state_reg <= asbla_pkg::ST_IDLE;
					end
				end
				default: begin
					state_reg <= asbla_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Phase counter
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count_reg <= asbla_pkg::COUNT_RESET;
		end else if (take && !reqWrite) begin
			count_reg <= asbla_pkg::RD_WAIT_COUNT;
		end else if (state_reg == asbla_pkg::ST_WR_SETUP) begin
			count_reg <= asbla_pkg::WR_PULSE_COUNT;
		end else if (state_reg == asbla_pkg::ST_RD_WAIT && countDone) begin
			count_reg <= asbla_pkg::TURN_COUNT;
		end else if (count_reg != asbla_pkg::COUNT_RESET) begin
			count_reg <= count_reg - asbla_pkg::COUNT_LAST;
		end
	end

	// Address, select and lane strobes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			addr_reg          <= asbla_pkg::ADDR_RESET;
			chipSelectN_reg   <= 1'b1;
			outputEnableN_reg <= 1'b1;
			byteEnN_reg       <= asbla_pkg::LANES_OFF_N;
		end else if (take) begin
			// Address changes on the same edge as select and lanes fall
			addr_reg          <= reqAddr;
			chipSelectN_reg   <= 1'b0;
			byteEnN_reg       <= ~reqByteEn;
			// Output enable stays high for writes so the device never drives back
			outputEnableN_reg <= reqWrite;
		end else if (state_reg == asbla_pkg::ST_WR_HOLD ||
				(state_reg == asbla_pkg::ST_RD_WAIT && countDone)) begin
			chipSelectN_reg   <= 1'b1;
			outputEnableN_reg <= 1'b1;
			byteEnN_reg       <= asbla_pkg::LANES_OFF_N;
		end
	end

	// Write strobe: falls last, rises first, so it alone bounds the write
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			writeStrobeN_reg <= 1'b1;
		end else if (state_reg == asbla_pkg::ST_WR_SETUP) begin
			writeStrobeN_reg <= 1'b0;
		end else if (state_reg == asbla_pkg::ST_WR_PULSE && countDone) begin
			// Rises one cycle before select, never together with it
			writeStrobeN_reg <= 1'b1;
		end
	end

	// Write data drive, only on enabled lanes, only while output enable is high
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dataOut_reg <= asbla_pkg::DATA_RESET;
			dataOe_reg  <= asbla_pkg::LANES_OFF;
		end else if (take && reqWrite) begin
			dataOut_reg <= reqData;
			// Disabled lanes stay floating and keep their stored bytes
			dataOe_reg  <= reqByteEn;
		end else if (state_reg == asbla_pkg::ST_WR_HOLD) begin
			// Data held through the strobe rise, released with select
			dataOe_reg  <= asbla_pkg::LANES_OFF;
		end
	end

	// Read capture and write acknowledge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rspValid_reg <= 1'b0;
			rspData_reg  <= asbla_pkg::DATA_RESET;
		end else if (state_reg == asbla_pkg::ST_RD_WAIT && countDone) begin
			rspValid_reg <= 1'b1;
			// Only lanes that were enabled carry read data
			rspData_reg  <= syncBus.syncData & laneMask(~byteEnN_reg);
		end else if (state_reg == asbla_pkg::ST_WR_HOLD) begin
			rspValid_reg <= 1'b1;
		end else begin
			rspValid_reg <= 1'b0;
		end
	end

	// Request handshake; turnaround after reads keeps drivers apart
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reqReady_reg <= 1'b1;
		end else if (take) begin
			reqReady_reg <= 1'b0;
		end else if (state_reg == asbla_pkg::ST_WR_HOLD ||
				(state_reg == asbla_pkg::ST_TURN && countDone)) begin
			reqReady_reg <= 1'b1;
		end
	end

	// Reads never lower the write strobe: it only moves in write states
	assign writeStrobeN        = writeStrobeN_reg;
	assign sramAddr            = addr_reg;
	assign chipSelectN         = chipSelectN_reg;
	assign outputEnableN       = outputEnableN_reg;
	assign upper_byte_enable_n = byteEnN_reg[1];
	assign lower_byte_enable_n = byteEnN_reg[0];
	assign sramDataOut         = dataOut_reg;
	assign sramDataOe          = dataOe_reg;
	assign reqReady            = reqReady_reg;
	assign rspValid            = rspValid_reg;
	assign rspData             = rspData_reg;

endmodule

// ==== hw/asbla_pin_sync.sv ====
// Two-stage synchroniser for the data pins coming back from the memory
`timescale 1ns/100ps
module asbla_pin_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic clock,
	input  wire logic rst,
	asbla_sync_if.capture port
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stage1_reg <= '0;
		end else begin
			stage1_reg <= port.rawData;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stage2_reg <= '0;
		end else begin
			stage2_reg <= stage1_reg;
		end
	end

	assign port.syncData = stage2_reg;

endmodule

// ==== hw/asbla_pkg.sv ====
// Constants, timing figures and state encoding for the static memory host controller
// How it works
// - Write starts once all strobes are low; any strobe rising ends it.
// - Write data set-up and hold refer to the edge ending the write.
// - Write strobe stays high for the whole of every read.
// - Address is valid no later than select and byte enables fall.
// - Controller never drives data while the device drives the pins.
package asbla_pkg;

	localparam int ADDR_WIDTH     = 17;
	localparam int DATA_WIDTH     = 16;
	localparam int LANE_WIDTH     = 8;
	localparam int LANE_COUNT     = 2;
	localparam int COUNT_WIDTH    = 4;
	localparam int SYNC_STAGES    = 2;

	// Clock
	localparam int CLOCK_PERIOD_NS = 20;

	// Device timing, 55 ns grade
	localparam int T_AA_NS   = 55;
	localparam int T_ACE_NS  = 55;
	localparam int T_DOE_NS  = 25;
	localparam int T_DBE_NS  = 25;
	localparam int T_HZOE_NS = 20;
	localparam int T_HZCE_NS = 20;
	localparam int T_PWE_NS  = 40;
	localparam int T_SCE_NS  = 45;
	localparam int T_BW_NS   = 50;
	localparam int T_SD_NS   = 25;

	// Least times round up, never below one cycle
	function automatic int ceilCycles(input int ns);
		int cycles;
		cycles = (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
		return (cycles < 1) ? 1 : cycles;
	endfunction

	function automatic int maxOf(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	// Read: longest of the access paths, then the pin synchroniser
	localparam int RD_ACCESS_CYCLES = maxOf(maxOf(ceilCycles(T_AA_NS), ceilCycles(T_ACE_NS)),
		maxOf(ceilCycles(T_DOE_NS), ceilCycles(T_DBE_NS)));
	localparam int RD_WAIT_CYCLES   = RD_ACCESS_CYCLES + SYNC_STAGES;
	// Bus turnaround after a read before anyone drives again
	localparam int TURN_CYCLES      = maxOf(ceilCycles(T_HZOE_NS), ceilCycles(T_HZCE_NS));
	// Write: one set-up cycle then the strobe pulse; select and lanes span both
	localparam int WR_PULSE_CYCLES  = maxOf(maxOf(ceilCycles(T_PWE_NS), ceilCycles(T_SD_NS) - 1),
		maxOf(ceilCycles(T_SCE_NS) - 1, ceilCycles(T_BW_NS) - 1));

	localparam logic [COUNT_WIDTH-1:0] RD_WAIT_COUNT  = COUNT_WIDTH'(RD_WAIT_CYCLES);
	localparam logic [COUNT_WIDTH-1:0] TURN_COUNT     = COUNT_WIDTH'(TURN_CYCLES);
	localparam logic [COUNT_WIDTH-1:0] WR_PULSE_COUNT = COUNT_WIDTH'(WR_PULSE_CYCLES);
	localparam logic [COUNT_WIDTH-1:0] COUNT_LAST     = 4'h1;

	// Reset values
	localparam logic [ADDR_WIDTH-1:0] ADDR_RESET   = 17'h00000;
	localparam logic [DATA_WIDTH-1:0] DATA_RESET   = 16'h0000;
	localparam logic [LANE_COUNT-1:0] LANES_OFF_N  = 2'h3;
	localparam logic [LANE_COUNT-1:0] LANES_OFF    = 2'h0;
	localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 4'h0;

	typedef enum logic [5:0] {
		ST_IDLE     = 6'h01,
		ST_WR_SETUP = 6'h02,
		ST_WR_PULSE = 6'h04,
		ST_WR_HOLD  = 6'h08,
		ST_RD_WAIT  = 6'h10,
		ST_TURN     = 6'h20
	} asbla_state_e;

endpackage

// ==== hw/asbla_sync_if.sv ====
// Carrier between the data pins and their synchroniser
`timescale 1ns/100ps
interface asbla_sync_if #(parameter int WIDTH = 16);

	logic [WIDTH-1:0] rawData;
	logic [WIDTH-1:0] syncData;

	modport capture (input rawData, output syncData);
	modport consumer (output rawData, input syncData);

endinterface

// ==== verification/asbla_host_properties.sv ====
// Concurrent checks on the static memory host pins
`timescale 1ns/100ps
module asbla_host_properties #(
	parameter int ADDR_WIDTH = 17
) (
	input wire logic                  clock,
	input wire logic                  rst,
	input wire logic                  reqValid,
	input wire logic                  reqWrite,
	input wire logic [ADDR_WIDTH-1:0] reqAddr,
	input wire logic [15:0]           reqData,
	input wire logic [1:0]            reqByteEn,
	input wire logic                  reqReady,
	input wire logic                  rspValid,
	input wire logic [ADDR_WIDTH-1:0] sramAddr,
	input wire logic                  chipSelectN,
	input wire logic                  writeStrobeN,
	input wire logic                  outputEnableN,
	input wire logic                  upper_byte_enable_n,
	input wire logic                  lower_byte_enable_n,
	input wire logic [15:0]           sramDataOut,
	input wire logic [1:0]            sramDataOe
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire take = reqValid && reqReady;
	sequence wrPulse;
		(!writeStrobeN && !chipSelectN)[*2];
	endsequence
	sequence wrFrame;
		(!chipSelectN && writeStrobeN) ##1 wrPulse ##1 (writeStrobeN && !chipSelectN)
			##1 (chipSelectN && rspValid);
	endsequence
	sequence rdFrame;
		(!chipSelectN && !outputEnableN && writeStrobeN)[*5] ##1 (chipSelectN && rspValid);
	endsequence
	a_write_steps: assert property (take && reqWrite |=> wrFrame)
		else $error("write strobe order wrong");
	a_write_lanes: assert property (take && reqWrite |=> sramDataOut == $past(reqData)
		&& sramDataOe == $past(reqByteEn)
		&& {upper_byte_enable_n, lower_byte_enable_n} == ~$past(reqByteEn))
		else $error("write lanes wrong");
	a_read_steps: assert property (take && !reqWrite |=> rdFrame)
		else $error("read strobe order wrong");
	a_addr_taken: assert property (take |=> sramAddr == $past(reqAddr) && !reqReady)
		else $error("address not presented");
	a_addr_stable: assert property (!chipSelectN && !$past(chipSelectN) |-> $stable(sramAddr))
		else $error("address moved while selected");
	a_deselect_quiet: assert property (chipSelectN |-> writeStrobeN && upper_byte_enable_n
		&& lower_byte_enable_n && sramDataOe == 2'h0)
		else $error("strobes active while deselected");
	a_read_no_drive: assert property (!outputEnableN |-> writeStrobeN && sramDataOe == 2'h0)
		else $error("host drives during read");
	a_write_oe_high: assert property (!writeStrobeN |-> outputEnableN && !chipSelectN)
		else $error("output enable low in write");
	a_data_held: assert property ($rose(writeStrobeN) |-> $stable(sramDataOut) && $stable(sramDataOe))
		else $error("write data not held at end");
endmodule
bind asbla_host asbla_host_properties #(.ADDR_WIDTH(ADDR_WIDTH)) props (
	.clock(clock), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
	.reqData(reqData), .reqByteEn(reqByteEn), .reqReady(reqReady), .rspValid(rspValid),
	.sramAddr(sramAddr), .chipSelectN(chipSelectN), .writeStrobeN(writeStrobeN),
	.outputEnableN(outputEnableN), .upper_byte_enable_n(upper_byte_enable_n),
	.lower_byte_enable_n(lower_byte_enable_n), .sramDataOut(sramDataOut), .sramDataOe(sramDataOe)
);

// ==== verification/asbla_sram_model.sv ====
// Behavioural 16-bit static memory with byte lanes
`timescale 1ns/100ps
module asbla_sram_model #(
	parameter int RD_DELAY_NS = 50
) (
	input wire logic        clock,
	input wire logic [16:0] addr,
	input wire logic        csN,
	input wire logic        weN,
	input wire logic        oeN,
	input wire logic        ubN,
	input wire logic        lbN,
	input wire logic [15:0] hostOut,
	input wire logic [1:0]  hostOe,
	output logic [15:0]     pins
);
	logic [15:0] mem [16];
	logic [15:0] floatPat = 16'h5a5a;
	logic [1:0]  en;
	logic [1:0]  enDly;
	logic        standby;
	wire  [3:0]  idx = addr[3:0];
	assign standby = csN;
	always @(posedge clock) floatPat <= ~floatPat;
	// Store only while select, strobe and a lane overlap
	always @* begin
		if (!standby && !weN) begin
			if (!lbN) mem[idx][7:0] = pins[7:0];
			if (!ubN) mem[idx][15:8] = pins[15:8];
		end
	end
	// Drive comes on late, goes off at once
	assign en = {!csN && weN && !oeN && !ubN, !csN && weN && !oeN && !lbN};
	assign #(RD_DELAY_NS) enDly = en;
	always @* begin
		for (int i = 0; i < 2; i++) begin
			if (hostOe[i]) pins[i*8 +: 8] = hostOut[i*8 +: 8];
			else if (en[i] && enDly[i]) pins[i*8 +: 8] = mem[idx][i*8 +: 8];
			else pins[i*8 +: 8] = floatPat[i*8 +: 8];
		end
	end
endmodule

// ==== verification/async_sram_byte_lane_access_test.sv ====
// Self-checking bench for the static memory host controller
`timescale 1ns/100ps
module async_sram_byte_lane_access_test;
	typedef struct {logic wr; logic [16:0] a; logic [15:0] d; logic [1:0] be; logic [15:0] exp;} asbla_row_s;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        reqValid = 1'b0;
	logic        reqWrite = 1'b0;
	logic [16:0] reqAddr = 17'h00000;
	logic [15:0] reqData = 16'h0000;
	logic [1:0]  reqByteEn = 2'h0;
	logic        reqReady, rspValid, chipSelectN, writeStrobeN, outputEnableN, ubN, lbN;
	logic [15:0] rspData, sramDataIn, sramDataOut;
	logic [16:0] sramAddr;
	logic [1:0]  sramDataOe;
	int          err_total = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          rspSeen = 0;
	asbla_row_s  rows [12] = '{
		'{1'b1, 17'h00001, 16'h1234, 2'h3, 16'h0000}, '{1'b0, 17'h00001, 16'h0000, 2'h3, 16'h1234},
		'{1'b1, 17'h00001, 16'h56ab, 2'h1, 16'h0000}, '{1'b0, 17'h00001, 16'h0000, 2'h3, 16'h12ab},
		'{1'b1, 17'h00001, 16'hcdff, 2'h2, 16'h0000}, '{1'b0, 17'h00001, 16'h0000, 2'h1, 16'h00ab},
		'{1'b0, 17'h00001, 16'h0000, 2'h2, 16'hcd00}, '{1'b1, 17'h00001, 16'hffff, 2'h0, 16'h0000},
		'{1'b0, 17'h00001, 16'h0000, 2'h3, 16'hcdab}, '{1'b0, 17'h00001, 16'h0000, 2'h0, 16'h0000},
		'{1'b1, 17'h1fff2, 16'hbeef, 2'h3, 16'h0000}, '{1'b0, 17'h1fff2, 16'h0000, 2'h3, 16'hbeef}};
	always #10 clock = ~clock;
	asbla_host dut (.clock(clock), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite),
		.reqAddr(reqAddr), .reqData(reqData), .reqByteEn(reqByteEn), .reqReady(reqReady),
		.rspValid(rspValid), .rspData(rspData), .sramAddr(sramAddr), .chipSelectN(chipSelectN),
		.writeStrobeN(writeStrobeN), .outputEnableN(outputEnableN), .upper_byte_enable_n(ubN),
		.lower_byte_enable_n(lbN), .sramDataIn(sramDataIn), .sramDataOut(sramDataOut),
		.sramDataOe(sramDataOe));
	asbla_sram_model mem (.clock(clock), .addr(sramAddr), .csN(chipSelectN), .weN(writeStrobeN),
		.oeN(outputEnableN), .ubN(ubN), .lbN(lbN), .hostOut(sramDataOut), .hostOe(sramDataOe),
		.pins(sramDataIn));
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic checkData(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic checkFlag(input logic got, input logic exp);
		checkData({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic issue(input asbla_row_s r);
		logic rdy;
		reqValid <= 1'b1;
		reqWrite <= r.wr;
		reqAddr <= r.a;
		reqData <= r.d;
		reqByteEn <= r.be;
		rdy = 1'b0;
		while (!rdy) begin
			@(negedge clock);
			rdy = reqReady;
			@(posedge clock);
		end
	endtask
	task automatic awaitRsp(output logic [15:0] d);
		int n;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (rspValid !== 1'b1 && n < 20);
		checkFlag(rspValid, 1'b1);
		d = rspData;
	endtask
	task automatic doReq(input asbla_row_s r, output logic [15:0] d);
		@(posedge clock);
		issue(r);
		reqValid <= 1'b0;
		awaitRsp(d);
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			test_done;
		end
	end
	// Counts every response pulse, write acknowledges included
	always @(negedge clock) begin
		if (rspValid === 1'b1) rspSeen++;
	end
	initial begin
		logic [15:0] got;
		int          seen0;
		repeat (4) @(posedge clock);
		@(negedge clock);
		checkFlag(chipSelectN & writeStrobeN & outputEnableN & ubN & lbN, 1'b1);
		checkFlag(reqReady, 1'b1);
		$display("reset test done");
		@(posedge clock);
		rst <= 1'b0;
		foreach (rows[i]) begin
			doReq(rows[i], got);
			if (!rows[i].wr) checkData(got, rows[i].exp);
		end
		$display("table test done");
		@(posedge clock);
		seen0 = rspSeen;
		issue(asbla_row_s'{1'b1, 17'h00005, 16'h9c3e, 2'h3, 16'h0000});
		issue(asbla_row_s'{1'b0, 17'h00005, 16'h0000, 2'h3, 16'h0000});
		reqValid <= 1'b0;
		awaitRsp(got);
		checkData(got, 16'h9c3e);
		@(posedge clock);
		checkData(16'(rspSeen - seen0), 16'h0002);
		$display("back-to-back test done");
		issue(asbla_row_s'{1'b1, 17'h00006, 16'h7711, 2'h3, 16'h0000});
		reqValid <= 1'b0;
		@(posedge clock);
		rst <= 1'b1;
		@(negedge clock);
		checkFlag(chipSelectN & writeStrobeN, 1'b1);
		checkData({14'h0000, sramDataOe}, 16'h0000);
		@(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		checkFlag(reqReady & chipSelectN, 1'b1);
		doReq(asbla_row_s'{1'b1, 17'h00007, 16'h4d2c, 2'h3, 16'h0000}, got);
		doReq(asbla_row_s'{1'b0, 17'h00007, 16'h0000, 2'h3, 16'h0000}, got);
		checkData(got, 16'h4d2c);
		$display("mid-write reset test done");
		test_done;
	end
endmodule
